// ===== verilog/dual_gain_serial_control.v
// Dual gain serial control with sample outputs and AXI4-Lite status
//
// Contract
// - Each amplifier gain follows its 6-bit gain word, driven in parallel.
// - Mode select level picks parallel load or up/down count operation.
// - Load mode: one serial bit enters shift stage per rising serial clock.
// - Load mode: select returning inactive copies shift stage into gain word.
// - Count mode (mode 0): rising clock with select active steps gain word.
// - Channel 1 alone selected: data 1 increments, data 0 decrements its word.
// - Channel 2 alone selected: data 1 increments, data 0 decrements its word.
// - Both selected: both words step together in direction of data.
// - Count mode: every stepping clock edge also shifts data into shift stage.
// - Each channel has own active-low select; controller lowers only wanted ones.
// - Amplifier enable is active low; high disables both amplifiers.
// - Sample words driven only while output enable input is low.
// - Track-hold enable low gives track-and-hold, else tracking only.
// - Edge rate select high changes output edge rate.
// - Each channel outputs an 8-bit binary sample, bit 7 most significant.
// - Count mode saturates at 63 upward and 0 downward.
// - Shift moves bits toward MSB, new bit enters at LSB.
// - Load mode: select rising edge loads word; both edges load both.
// - Edge rate select low gives maximum slew, high minimum slew.
`timescale 1ns/1ns
`include "gain_ctrl_consts.vh"
module dual_gain_serial_control (
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite slave
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	// Serial gain interface pins
	input wire gain_serial_clk,
	input wire gain_serial_in,
	input wire gain_mode_select,
	input wire chan1_gain_select_n,
	input wire chan2_gain_select_n,
	// Static control pins
	input wire amp_enable_n,
	input wire track_hold_enable_n,
	input wire output_enable_n,
	input wire edge_rate_select,
	// Converter side
	input wire chan1_conv_clk,
	input wire [7:0] chan1_conv_data,
	input wire chan2_conv_clk,
	input wire [7:0] chan2_conv_data,
	// Amplifier and converter controls
	output wire [5:0] chan1_gain_word,
	output wire [5:0] chan2_gain_word,
	output wire chan1_amp_on,
	output wire chan2_amp_on,
	output wire track_hold_on,
	output wire edge_rate_slow,
	// Sample outputs with drive enables
	output wire [7:0] chan1_sample,
	output wire chan1_sample_oe,
	output wire [7:0] chan2_sample,
	output wire chan2_sample_oe
);

	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************
	wire [26:0] pins_sync;

	// One stage count for every pin, so data lines up with the clock edge found beside it
	// Active-low pins enter inverted: cleared stages read idle, so no false edge after reset
	// Sample capture is limited to converter clocks well under aclk/2
	sync2 #(.WIDTH(27)) pin_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({gain_serial_clk, gain_serial_in, gain_mode_select,
			~chan1_gain_select_n, ~chan2_gain_select_n, ~amp_enable_n, ~track_hold_enable_n,
			~output_enable_n, edge_rate_select,
			chan1_conv_clk, chan1_conv_data, chan2_conv_clk, chan2_conv_data}),
		.sync_out(pins_sync)
	);

	wire sclk_s = pins_sync[26];
	wire gain_serial_in_s = pins_sync[25];
	wire mode_s = pins_sync[24];
	wire sel1_n_s = ~pins_sync[23];
	wire sel2_n_s = ~pins_sync[22];
	wire amp_en_n_s = ~pins_sync[21];
	wire th_en_n_s = ~pins_sync[20];
	wire oe_n_s = ~pins_sync[19];
	wire rate_s = pins_sync[18];
	wire cclk1_s = pins_sync[17];
	wire [7:0] cdata1_s = pins_sync[16:9];
	wire cclk2_s = pins_sync[8];
	wire [7:0] cdata2_s = pins_sync[7:0];

	// ****************************************************************
	// Edge detection
	// ****************************************************************
	reg sclk_prev_reg;
	reg sel1_n_prev_reg;
	reg sel2_n_prev_reg;
	reg cclk1_prev_reg;
	reg cclk2_prev_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			sclk_prev_reg <= 1'b0;
			sel1_n_prev_reg <= 1'b1;
			sel2_n_prev_reg <= 1'b1;
			cclk1_prev_reg <= 1'b0;
			cclk2_prev_reg <= 1'b0;
		end else begin
			sclk_prev_reg <= sclk_s;
			sel1_n_prev_reg <= sel1_n_s;
			sel2_n_prev_reg <= sel2_n_s;
			cclk1_prev_reg <= cclk1_s;
			cclk2_prev_reg <= cclk2_s;
		end
	end

	wire sclk_rise = sclk_s & ~sclk_prev_reg;
	wire sel1_rise = sel1_n_s & ~sel1_n_prev_reg;
	wire sel2_rise = sel2_n_s & ~sel2_n_prev_reg;

	// ****************************************************************
	// Gain words and shift stage
	// ****************************************************************
	reg [5:0] shift_reg;
	reg [5:0] gain1_reg;
	reg [5:0] gain2_reg;
	reg serial_en_reg;

	// Saturating one-step counter
	function [5:0] step_gain;
		input [5:0] word;
		input up;
		begin
			if (up) begin
				step_gain = (word == `GAIN_MAX) ? word : word + 6'h01;
			end else begin
				step_gain = (word == `GAIN_MIN) ? word : word - 6'h01;
			end
		end
	endfunction

	always @(posedge aclk) begin
		if (!aresetn) begin
			shift_reg <= `SHIFT_RST;
			gain1_reg <= `GAIN_RST;
			gain2_reg <= `GAIN_RST;
		end else if (serial_en_reg) begin
			if (sclk_rise) begin
				// Shift on every rising serial edge in both modes
				shift_reg <= {shift_reg[4:0], gain_serial_in_s};
			end
			if (mode_s) begin
				// Parallel load; a load and a shift in one cycle take the old stage
				if (sel1_rise) begin
					gain1_reg <= shift_reg;
				end
				if (sel2_rise) begin
					gain2_reg <= shift_reg;
				end
			end else if (sclk_rise) begin
				// Count mode, selects decide which words step
				if (!sel1_n_s) begin
					gain1_reg <= step_gain(gain1_reg, gain_serial_in_s);
				end
				if (!sel2_n_s) begin
					gain2_reg <= step_gain(gain2_reg, gain_serial_in_s);
				end
			end
		end
	end

	// ****************************************************************
	// Static controls and sample outputs
	// ****************************************************************
	reg amp_on_reg;
	reg th_on_reg;
	reg rate_slow_reg;
	reg oe_reg;
	reg [7:0] sample1_reg;
	reg [7:0] sample2_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			amp_on_reg <= 1'b0;
			th_on_reg <= 1'b0;
			rate_slow_reg <= 1'b0;
			oe_reg <= 1'b0;
			sample1_reg <= 8'h00;
			sample2_reg <= 8'h00;
		end else begin
			amp_on_reg <= ~amp_en_n_s;
			th_on_reg <= ~th_en_n_s;
			rate_slow_reg <= rate_s;
			oe_reg <= ~oe_n_s;
			if (cclk1_s && !cclk1_prev_reg) begin
				sample1_reg <= cdata1_s;
			end
			if (cclk2_s && !cclk2_prev_reg) begin
				sample2_reg <= cdata2_s;
			end
		end
	end

	assign chan1_gain_word = gain1_reg;
	assign chan2_gain_word = gain2_reg;
	assign chan1_amp_on = amp_on_reg;
	assign chan2_amp_on = amp_on_reg;
	assign track_hold_on = th_on_reg;
	assign edge_rate_slow = rate_slow_reg;
	assign chan1_sample = sample1_reg;
	assign chan2_sample = sample2_reg;
	assign chan1_sample_oe = oe_reg;
	assign chan2_sample_oe = oe_reg;

	// ****************************************************************
	// AXI4-Lite write channel
	// ****************************************************************
	reg awready_reg;
	reg wready_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;
	reg aw_full_reg;
	reg w_full_reg;
	reg [3:0] waddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			waddr_reg <= 4'h0;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			serial_en_reg <= `CTRL_SERIAL_EN_RST;
		end else begin
			if (s_axi_awvalid && awready_reg) begin
				waddr_reg <= s_axi_awaddr;
				aw_full_reg <= 1'b1;
				awready_reg <= 1'b0;
			end
			if (s_axi_wvalid && wready_reg) begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				w_full_reg <= 1'b1;
				wready_reg <= 1'b0;
			end
			if (aw_full_reg && w_full_reg && !bvalid_reg) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				// Read-only registers take writes quietly; only the unused slot answers an error
				bresp_reg <= ({waddr_reg[3:2], 2'b00} > `OFS_SAMPLES) ? `RESP_SLVERR : `RESP_OKAY;
				if ({waddr_reg[3:2], 2'b00} == `OFS_CTRL && wstrb_reg[0]) begin
					serial_en_reg <= wdata_reg[`CTRL_SERIAL_EN_BIT];
				end
			end
			if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************
	reg arready_reg;
	reg rvalid_reg;
	reg [1:0] rresp_reg;
	reg [31:0] rdata_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rresp_reg <= `RESP_OKAY;
			rdata_reg <= 32'h00000000;
		end else begin
			if (s_axi_arvalid && arready_reg) begin
				arready_reg <= 1'b0;
				rvalid_reg <= 1'b1;
				rresp_reg <= `RESP_OKAY;
				rdata_reg <= 32'h00000000;
				case ({s_axi_araddr[3:2], 2'b00})
					`OFS_CTRL: rdata_reg[`CTRL_SERIAL_EN_BIT] <= serial_en_reg;
					`OFS_STATUS: begin
						rdata_reg[`ST_GAIN1_LSB +: 6] <= gain1_reg;
						rdata_reg[`ST_GAIN2_LSB +: 6] <= gain2_reg;
						rdata_reg[`ST_SHIFT_LSB +: 6] <= shift_reg;
						rdata_reg[`ST_MODE_BIT] <= mode_s;
						rdata_reg[`ST_SEL1_BIT] <= sel1_n_s;
						rdata_reg[`ST_SEL2_BIT] <= sel2_n_s;
					end
					`OFS_SAMPLES: begin
						rdata_reg[`SMP_CHAN1_LSB +: 8] <= sample1_reg;
						rdata_reg[`SMP_CHAN2_LSB +: 8] <= sample2_reg;
					end
					default: rresp_reg <= `RESP_SLVERR;
				endcase
			end
			if (rvalid_reg && s_axi_rready) begin
				rvalid_reg <= 1'b0;
				arready_reg <= 1'b1;
			end
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
endmodule // dual_gain_serial_control

// ===== verilog/gain_ctrl_consts.vh
// Constants for the dual gain serial control block
`ifndef GAIN_CTRL_CONSTS_VH
`define GAIN_CTRL_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_SAMPLES 4'h8

// ****************************************************************
// Field positions and widths
// ****************************************************************
`define GAIN_W 6
`define SAMPLE_W 8
`define CTRL_SERIAL_EN_BIT 0
`define ST_GAIN1_LSB 0
`define ST_GAIN2_LSB 8
`define ST_SHIFT_LSB 16
`define ST_MODE_BIT 24
`define ST_SEL1_BIT 25
`define ST_SEL2_BIT 26
`define SMP_CHAN1_LSB 0
`define SMP_CHAN2_LSB 8

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define CTRL_SERIAL_EN_RST 1'b1
`define GAIN_RST 6'h00
`define SHIFT_RST 6'h00
`define GAIN_MAX 6'h3F
`define GAIN_MIN 6'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== verilog/sync2.v
// Two-flop synchroniser for levels entering the aclk domain
`timescale 1ns/1ns
module sync2 #(
	parameter WIDTH = 1
) (
	input wire aclk,
	input wire aresetn,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;

	// Only stage2 reads stage1; nothing else may look at it
	always @(posedge aclk) begin
		if (!aresetn) begin
			stage1_reg <= {WIDTH{1'b0}};
			stage2_reg <= {WIDTH{1'b0}};
		end else begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
		end
	end

	assign sync_out = stage2_reg;
endmodule // sync2

// ===== dv/dual_gain_serial_control_checker.sv
// Port-level assertions for the dual gain serial control block
`timescale 1ns/1ns
module dual_gain_serial_control_checker (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire gain_mode_select,
	input wire [5:0] chan1_gain_word,
	input wire amp_enable_n,
	input wire track_hold_enable_n,
	input wire output_enable_n,
	input wire edge_rate_select,
	input wire chan1_amp_on,
	input wire chan2_amp_on,
	input wire track_hold_on,
	input wire edge_rate_slow,
	input wire chan1_sample_oe,
	input wire chan2_sample_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Pins settle in 3 edges; 5 stable samples leave a margin
	a_amp_follow: assert property ($stable(amp_enable_n)[*5] |->
		{chan1_amp_on, chan2_amp_on} == ~{2{amp_enable_n}}) else $error("amp enable wrong");
	a_track_follow: assert property ($stable(track_hold_enable_n)[*5] |->
		track_hold_on != track_hold_enable_n) else $error("track-hold wrong");
	a_drive_follow: assert property ($stable(output_enable_n)[*5] |->
		{chan1_sample_oe, chan2_sample_oe} == ~{2{output_enable_n}}) else $error("drive wrong");
	a_slew_follow: assert property ($stable(edge_rate_select)[*5] |->
		edge_rate_slow == edge_rate_select) else $error("edge rate wrong");
	a_count_step: assert property ((!gain_mode_select)[*6] ##0 $changed(chan1_gain_word) |->
		{1'b0, chan1_gain_word} == {1'b0, $past(chan1_gain_word)} + 7'h01 ||
		{1'b0, chan1_gain_word} + 7'h01 == {1'b0, $past(chan1_gain_word)})
		else $error("gain step not one");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
	a_write_close: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not closed");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hC
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
endmodule // dual_gain_serial_control_checker

// ===== dv/gain_link_model.sv
// Behavioural serial controller for the gain interface pins
`timescale 1ns/1ns
module gain_link_model (
	output logic gain_serial_clk,
	output logic gain_serial_in,
	output logic gain_mode_select,
	output logic chan1_gain_select_n,
	output logic chan2_gain_select_n
);
	initial begin
		gain_serial_clk = 1'b0;
		gain_serial_in = 1'b0;
		gain_mode_select = 1'b1;
		{chan1_gain_select_n, chan2_gain_select_n} = 2'b11;
	end
	// One frame of n bits; the link clock idles low between frames
	task automatic frame(input logic m, input logic [1:0] sel, input logic [5:0] w, input int n);
		#7 gain_mode_select = m;
		{chan2_gain_select_n, chan1_gain_select_n} = ~sel;
		for (int i = n - 1; i >= 0; i--) begin
			gain_serial_in = w[i];
			#160 gain_serial_clk = 1'b1;
			#160 gain_serial_clk = 1'b0;
		end
		#160 {chan1_gain_select_n, chan2_gain_select_n} = 2'b11;
		// Released data must not keep looking valid
		gain_serial_in = ~gain_serial_in;
		#320;
	endtask
endmodule // gain_link_model

// ===== dv/dual_gain_serial_control_tb_top.sv
// Self-checking bench for the dual gain serial control block
`timescale 1ns/1ns
module dual_gain_serial_control_tb_top;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic gain_serial_clk, gain_serial_in, gain_mode_select;
	logic chan1_gain_select_n, chan2_gain_select_n, edge_rate_select;
	logic amp_enable_n, track_hold_enable_n, output_enable_n;
	logic chan1_conv_clk, chan2_conv_clk, chan1_sample_oe, chan2_sample_oe;
	logic [7:0] chan1_conv_data, chan2_conv_data, chan1_sample, chan2_sample;
	logic [5:0] chan1_gain_word, chan2_gain_word;
	logic chan1_amp_on, chan2_amp_on, track_hold_on, edge_rate_slow;
	int err_count = 0;
	int samples_checked = 0;

	dual_gain_serial_control dut_u (.*);
	gain_link_model lnk_u (.*);

	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Bounded wait on bvalid (0), arready (1) or rvalid (2)
	task automatic wait_on(input int k);
		int n;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while ((k == 0 ? s_axi_bvalid : k == 1 ? s_axi_arready : s_axi_rvalid) !== 1'b1
			&& n < 200);
		if (n >= 200) begin
			err_count++;
			$display("ERROR %0t: bus timeout", $time);
			give_verdict;
		end
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (int n = 0; n < 200 && (aw || w); n++) begin
			@(posedge aclk);
			aw = aw && !s_axi_awready;
			w = w && !s_axi_wready;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		s_axi_bready <= 1'b1;
		wait_on(0);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(er));
	endtask
	task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		wait_on(1);
		s_axi_arvalid <= 1'b0;
		wait_on(2);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, ed);
		chk(32'(s_axi_rresp), 32'(er));
	endtask
	task automatic gains(input logic [5:0] e1, input logic [5:0] e2);
		@(posedge aclk);
		chk(32'({chan1_gain_word, chan2_gain_word}), 32'({e1, e2}));
	endtask

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	// ****************
	// Main sequence
	// ****************
	initial begin
		logic b;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{amp_enable_n, track_hold_enable_n, output_enable_n, edge_rate_select} = '0;
		{chan1_conv_clk, chan2_conv_clk, chan1_conv_data, chan2_conv_data} = '0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(4'h0, 32'h1, 2'h0);
		gains(6'h00, 6'h00);
		lnk_u.frame(1'b1, 2'b01, 6'h2D, 6);
		gains(6'h2D, 6'h00);
		lnk_u.frame(1'b1, 2'b10, 6'h15, 6);
		gains(6'h2D, 6'h15);
		lnk_u.frame(1'b1, 2'b11, 6'h3E, 6);
		gains(6'h3E, 6'h3E);
		lnk_u.frame(1'b0, 2'b01, 6'h3F, 3);
		gains(6'h3F, 6'h3E);
		lnk_u.frame(1'b0, 2'b10, 6'h00, 2);
		gains(6'h3F, 6'h3C);
		lnk_u.frame(1'b1, 2'b11, 6'h01, 6);
		lnk_u.frame(1'b0, 2'b11, 6'h00, 3);
		gains(6'h00, 6'h00);
		lnk_u.frame(1'b0, 2'b11, 6'h3F, 1);
		gains(6'h01, 6'h01);
		lnk_u.frame(1'b1, 2'b00, 6'h2B, 6);
		lnk_u.frame(1'b0, 2'b01, 6'h3F, 2);
		gains(6'h03, 6'h01);
		axi_rd(4'h4, 32'h062F_0103, 2'h0);
		$display("Serial test done");
		axi_wr(4'h0, 32'h0, 2'h0);
		lnk_u.frame(1'b0, 2'b01, 6'h3F, 1);
		gains(6'h03, 6'h01);
		axi_rd(4'h4, 32'h062F_0103, 2'h0);
		axi_wr(4'h0, 32'h1, 2'h0);
		axi_wr(4'hC, 32'hFFFF_FFFF, 2'h2);
		axi_rd(4'hC, 32'h0, 2'h2);
		axi_wr(4'h4, 32'h0, 2'h0);
		s_axi_wstrb <= 4'hE;
		axi_wr(4'h0, 32'h0, 2'h0);
		s_axi_wstrb <= 4'hF;
		axi_rd(4'h0, 32'h1, 2'h0);
		$display("Register test done");
		for (int v = 1; v >= 0; v--) begin
			b = v[0];
			{amp_enable_n, track_hold_enable_n, output_enable_n, edge_rate_select} <= {4{b}};
			repeat (5) @(posedge aclk);
			chk(32'({chan1_amp_on, chan2_amp_on, track_hold_on}), 32'({3{~b}}));
			chk(32'({chan1_sample_oe, chan2_sample_oe}), 32'({2{~b}}));
			chk(32'(edge_rate_slow), 32'(b));
		end
		chan1_conv_data <= 8'hA5;
		chan2_conv_data <= 8'h3C;
		repeat (4) @(posedge aclk);
		{chan1_conv_clk, chan2_conv_clk} <= 2'b11;
		repeat (4) @(posedge aclk);
		{chan1_conv_clk, chan2_conv_clk} <= 2'b00;
		repeat (4) @(posedge aclk);
		chk(32'({chan2_sample, chan1_sample}), 32'h3CA5);
		axi_rd(4'h8, 32'h0000_3CA5, 2'h0);
		$display("Pin test done");
		give_verdict;
	end
endmodule // dual_gain_serial_control_tb_top

bind dual_gain_serial_control dual_gain_serial_control_checker chk_u (.*);
